// File: src/tcw_control_word_a.sv
// Overview of operation
// - pins both low load band 1, vco 11, dividers 16, n 1919 and 1943
// - other pin pairs load their own band, vco, divider and n defaults
// - receive reference divider in bits 9:0, legal range 4 to 1023
// - mode bits 11:10: standby, receive, transmit, idle
// - bit 12 picks amp gain, only under internal gain control
// - bit 16 zero: amp on after lock; one: always on in transmit
// - bit 17 zero: lock held once seen; one: lock tracked continuously
// - bit 18 picks pump current, low or high
// - bit 19 picks ask or fsk, only under internal modulation control
// - bit 20 inverts the mapping of input data to symbol
// - bit 21 zero: only oscillator in idle; one: whole pll active
// - serial data shifted msb first on rising serial clock, 24 kept
// - rising serial enable copies shift register to word addressed 00
// - first change on select-0/enable pin enters programmable mode
`timescale 1ns/1ps
`default_nettype none

module tcw_control_word_a (
   // clocks and reset
   input  wire logic                       sys_clk_i,
   input  wire logic                       reset_i,
   input  wire logic                       serial_clk_i,
   // serial control port
   input  wire logic                       serial_data_in_i,
   input  wire logic                       serial_enable_i,
   // frequency select strap
   input  wire logic                       freq_select_1_i,
   // analog and datapath status
   input  wire logic                       pll_lock_i,
   input  wire logic                       tx_data_i,
   input  wire logic                       gain_control_source_i,
   input  wire logic                       amp_gain_ext_i,
   input  wire logic                       modulation_source_i,
   input  wire logic                       modulation_ext_i,
   // mode and power control
   output logic                            programmable_mode_o,
   output logic      [1:0]                 operating_mode_o,
   output logic                            ref_osc_active_o,
   output logic                            pll_active_o,
   output logic                            pa_enable_o,
   output logic                            lock_indicator_o,
   // word fields
   output logic      [9:0]                 rx_ref_divider_o,
   output logic                            amp_gain_sel_o,
   output logic      [1:0]                 output_power_step_o,
   output logic                            pump_high_current_o,
   output logic                            modulation_sel_o,
   output logic                            tx_symbol_o,
   output logic                            idle_scope_o,
   output logic                            rx_div_rejected_o,
   // pin defaults
   output logic                            band_o,
   output logic      [1:0]                 vco_current_code_o,
   output logic      [9:0]                 tx_ref_divider_o,
   output logic      [tcw_pkg::N_W-1:0]    rx_feedback_divider_o,
   output logic      [tcw_pkg::N_W-1:0]    tx_feedback_divider_o
);

   // ***********************************************************
   // pin synchronisation and link
   // ***********************************************************
   logic [3:0]                   pins_s;
   logic                         en_s;
   logic                         fs1_s;
   logic                         lock_s;
   logic                         data_s;
   logic [tcw_pkg::WORD_W-1:0]   shift_w;

   tcw_sync #(
      .WIDTH (4)
   ) u_sync (
      .sys_clk_i (sys_clk_i),
      .reset_i   (reset_i),
      .async_i   ({tx_data_i, pll_lock_i, freq_select_1_i, serial_enable_i}),
      .sync_o    (pins_s)
   );

   assign en_s   = pins_s[0];
   assign fs1_s  = pins_s[1];
   assign lock_s = pins_s[2];
   assign data_s = pins_s[3];

   // host holds serial clock still while enable rises, so the
   // shift register is static when sampled below
   tcw_shift u_shift (
      .serial_clk_i     (serial_clk_i),
      .reset_i          (reset_i),
      .serial_data_in_i (serial_data_in_i),
      .shift_o          (shift_w)
   );

   // ***********************************************************
   // mode entry and write strobe
   // ***********************************************************
   logic                         en_prev_q;
   logic                         ref_valid_q;
   logic                         ref_level_q;
   logic [1:0]                   settle_q;
   logic                         prog_q;
   logic                         pin_changed;
   logic                         enable_rise;
   logic                         write_a;
   logic                         rr_ok;
   logic [1:0]                   sel;

   assign pin_changed = ref_valid_q && (en_s != ref_level_q);
   assign enable_rise = en_s && !en_prev_q;
   assign sel         = {fs1_s, en_s};
   assign rr_ok       = (shift_w[9:0] >= tcw_pkg::RR_MIN) &&
                        (shift_w[9:0] <= tcw_pkg::RR_MAX);

   assign write_a = enable_rise && (prog_q || pin_changed) &&
                    (shift_w[tcw_pkg::ADDR_HI:tcw_pkg::ADDR_LO] == tcw_pkg::ADDR_A);

   always_ff @(posedge sys_clk_i or posedge reset_i) begin
      if (reset_i) begin
         en_prev_q <= 1'b0;
      end else begin
         en_prev_q <= en_s;
      end
   end

   // wait until the synchroniser holds the real pin level
   always_ff @(posedge sys_clk_i or posedge reset_i) begin
      if (reset_i) begin
         settle_q <= 2'h0;
      end else if (settle_q != 2'h2) begin
         settle_q <= settle_q + 2'h1;
      end
   end

   // pin level caught once settled, then watched
   always_ff @(posedge sys_clk_i or posedge reset_i) begin
      if (reset_i) begin
         ref_valid_q <= 1'b0;
         ref_level_q <= 1'b0;
      end else if (!ref_valid_q && settle_q == 2'h2) begin
         ref_valid_q <= 1'b1;
         ref_level_q <= en_s;
      end
   end

   always_ff @(posedge sys_clk_i or posedge reset_i) begin
      if (reset_i) begin
         prog_q <= 1'b0;
      end else if (pin_changed) begin
         prog_q <= 1'b1;
      end
   end

   // ***********************************************************
   // control word a
   // ***********************************************************
   logic [tcw_pkg::DATA_W-1:0]   word_q;
   tcw_pkg::tcw_mode_t           mode_w;

   assign mode_w = tcw_pkg::tcw_mode_t'(word_q[tcw_pkg::MODE_LO +: 2]);

   // fields held until rewritten, also across standby; divider tracks pin default until programmable mode
   always_ff @(posedge sys_clk_i or posedge reset_i) begin
      if (reset_i) begin
         word_q <= {tcw_pkg::A_UPPER_RST, tcw_pkg::REF_DIV_00};
      end else if (write_a) begin
         word_q[tcw_pkg::DATA_W-1:tcw_pkg::RR_W] <= shift_w[tcw_pkg::DATA_W-1:tcw_pkg::RR_W];
         // out of range divider kept out
         if (rr_ok) begin
            word_q[tcw_pkg::RR_W-1:0] <= shift_w[tcw_pkg::RR_W-1:0];
         end
      end else if (!prog_q) begin
         word_q[tcw_pkg::RR_W-1:0] <= tcw_pkg::dflt_ref(sel);
      end
   end

   always_ff @(posedge sys_clk_i or posedge reset_i) begin
      if (reset_i) begin
         rx_div_rejected_o <= 1'b0;
      end else if (write_a) begin
         rx_div_rejected_o <= !rr_ok;
      end
   end

   assign programmable_mode_o = prog_q;
   assign operating_mode_o    = word_q[tcw_pkg::MODE_LO +: 2];
   assign rx_ref_divider_o    = word_q[tcw_pkg::RR_W-1:0];
   assign output_power_step_o = word_q[tcw_pkg::POWER_LO +: 2];
   assign pump_high_current_o = word_q[tcw_pkg::PUMP_BIT];
   assign idle_scope_o        = word_q[tcw_pkg::IDLE_BIT];

   // ***********************************************************
   // pin defaults for the other words
   // ***********************************************************
   // table by select pins, frozen in programmable mode
   always_ff @(posedge sys_clk_i or posedge reset_i) begin
      if (reset_i) begin
         band_o                <= tcw_pkg::BAND_TABLE[0];
         vco_current_code_o    <= tcw_pkg::VCO_TABLE[1:0];
         tx_ref_divider_o      <= tcw_pkg::REF_DIV_00;
         rx_feedback_divider_o <= tcw_pkg::RX_N_00;
         tx_feedback_divider_o <= tcw_pkg::TX_N_00;
      end else if (!prog_q) begin
         band_o                <= tcw_pkg::BAND_TABLE[sel];
         vco_current_code_o    <= tcw_pkg::VCO_TABLE[2*sel +: 2];
         tx_ref_divider_o      <= tcw_pkg::dflt_ref(sel);
         rx_feedback_divider_o <= tcw_pkg::dflt_rx_n(sel);
         tx_feedback_divider_o <= tcw_pkg::dflt_tx_n(sel);
      end
   end

   // ***********************************************************
   // power scope
   // ***********************************************************
   // block enables by mode
   always_ff @(posedge sys_clk_i or posedge reset_i) begin
      if (reset_i) begin
         ref_osc_active_o <= 1'b0;
         pll_active_o     <= 1'b0;
      end else begin
         case (mode_w)
            tcw_pkg::TCW_STANDBY: begin
               ref_osc_active_o <= 1'b0;
               pll_active_o     <= 1'b0;
            end
            tcw_pkg::TCW_IDLE: begin
               ref_osc_active_o <= 1'b1;
               pll_active_o     <= word_q[tcw_pkg::IDLE_BIT];
            end
            default: begin
               ref_osc_active_o <= 1'b1;
               pll_active_o     <= 1'b1;
            end
         endcase
      end
   end

   // ***********************************************************
   // lock observation and amplifier
   // ***********************************************************
   logic                         lock_seen_q;
   logic                         lock_seen_d;
   logic                         standby;

   assign standby = (mode_w == tcw_pkg::TCW_STANDBY);

   always_comb begin
      if (standby || write_a) begin
         lock_seen_d = 1'b0;
      end else begin
         lock_seen_d = lock_seen_q || lock_s;
      end
   end

   always_ff @(posedge sys_clk_i or posedge reset_i) begin
      if (reset_i) begin
         lock_seen_q <= 1'b0;
      end else begin
         lock_seen_q <= lock_seen_d;
      end
   end

   always_ff @(posedge sys_clk_i or posedge reset_i) begin
      if (reset_i) begin
         lock_indicator_o <= 1'b0;
      end else if (word_q[tcw_pkg::WATCH_BIT]) begin
         lock_indicator_o <= lock_s && !standby;
      end else begin
         lock_indicator_o <= lock_seen_d;
      end
   end

   always_ff @(posedge sys_clk_i or posedge reset_i) begin
      if (reset_i) begin
         pa_enable_o <= 1'b0;
      end else begin
         pa_enable_o <= (mode_w == tcw_pkg::TCW_TRANSMIT) &&
                        (word_q[tcw_pkg::POLICY_BIT] || lock_indicator_o);
      end
   end

   // ***********************************************************
   // gain, modulation and data polarity
   // ***********************************************************
   always_ff @(posedge sys_clk_i or posedge reset_i) begin
      if (reset_i) begin
         amp_gain_sel_o   <= 1'b0;
         modulation_sel_o <= 1'b0;
         tx_symbol_o      <= 1'b0;
      end else begin
         amp_gain_sel_o   <= (gain_control_source_i == tcw_pkg::INTERNAL_SRC) ?
                             word_q[tcw_pkg::GAIN_BIT] : amp_gain_ext_i;
         modulation_sel_o <= (modulation_source_i == tcw_pkg::INTERNAL_SRC) ?
                             word_q[tcw_pkg::MODULATION_SEL_BIT] : modulation_ext_i;
         tx_symbol_o      <= data_s ^ word_q[tcw_pkg::POL_BIT];
      end
   end

   // ***********************************************************
   // checks
   // ***********************************************************
   property p_latch;
      @(posedge sys_clk_i) disable iff (reset_i)
      write_a |=> word_q[21:10] == $past(shift_w[21:10]);
   endproperty
   a_latch: assert property (p_latch)
      else $error("word not latched on enable rise");

   property p_other_addr;
      @(posedge sys_clk_i) disable iff (reset_i)
      (enable_rise && shift_w[23:22] != 2'h0) |=> $stable(word_q[21:10]);
   endproperty
   a_other_addr: assert property (p_other_addr)
      else $error("word changed by other address");

   property p_div_range;
      @(posedge sys_clk_i) disable iff (reset_i)
      (write_a && shift_w[9:0] < 10'h004) |=> $stable(word_q[9:0]) && rx_div_rejected_o;
   endproperty
   a_div_range: assert property (p_div_range)
      else $error("illegal divider accepted");

   property p_prog_entry;
      @(posedge sys_clk_i) disable iff (reset_i)
      pin_changed |=> prog_q [*3];
   endproperty
   a_prog_entry: assert property (p_prog_entry)
      else $error("programmable mode not entered or lost");

   property p_default_00;
      @(posedge sys_clk_i) disable iff (reset_i)
      (!prog_q && sel == 2'h0) |=> rx_feedback_divider_o == 17'h0077F &&
         tx_feedback_divider_o == 17'h00797 && band_o && vco_current_code_o == 2'h3;
   endproperty
   a_default_00: assert property (p_default_00)
      else $error("default for pins 00 wrong");

   property p_default_11;
      @(posedge sys_clk_i) disable iff (reset_i)
      (!prog_q && sel == 2'h3) |=> tx_ref_divider_o == 10'h012 && !band_o &&
         rx_feedback_divider_o == 17'h002FE;
   endproperty
   a_default_11: assert property (p_default_11)
      else $error("default for pins 11 wrong");

   property p_idle_scope;
      @(posedge sys_clk_i) disable iff (reset_i)
      (mode_w == tcw_pkg::TCW_IDLE) |=> ref_osc_active_o && pll_active_o == $past(word_q[21]);
   endproperty
   a_idle_scope: assert property (p_idle_scope)
      else $error("idle scope wrong");

   property p_standby;
      @(posedge sys_clk_i) disable iff (reset_i)
      standby |=> !ref_osc_active_o && !pll_active_o && !pa_enable_o;
   endproperty
   a_standby: assert property (p_standby)
      else $error("blocks active in standby");

   property p_pa_wait;
      @(posedge sys_clk_i) disable iff (reset_i)
      (!word_q[16] && !lock_indicator_o) |=> !pa_enable_o;
   endproperty
   a_pa_wait: assert property (p_pa_wait)
      else $error("amplifier on before lock");

   property p_lock_hold;
      @(posedge sys_clk_i) disable iff (reset_i)
      (!word_q[17] && !$past(write_a) && lock_indicator_o && !standby && !write_a)
         |=> lock_indicator_o;
   endproperty
   a_lock_hold: assert property (p_lock_hold)
      else $error("held lock dropped");

   property p_gain;
      @(posedge sys_clk_i) disable iff (reset_i)
      (!gain_control_source_i) |=> amp_gain_sel_o == $past(word_q[12]);
   endproperty
   a_gain: assert property (p_gain)
      else $error("internal gain not applied");

   property p_mod;
      @(posedge sys_clk_i) disable iff (reset_i)
      modulation_source_i |=> modulation_sel_o == $past(modulation_ext_i);
   endproperty
   a_mod: assert property (p_mod)
      else $error("register modulation used under external control");

endmodule : tcw_control_word_a

`default_nettype wire

// File: src/tcw_pkg.sv
package tcw_pkg;

   // ***********************************************************
   // word layout
   // ***********************************************************
   localparam int WORD_W     = 24;
   localparam int ADDR_HI    = 23;
   localparam int ADDR_LO    = 22;
   localparam int DATA_W     = 22;
   localparam int RR_W       = 10;
   localparam int RR_LO      = 0;
   localparam int MODE_LO    = 10;
   localparam int GAIN_BIT   = 12;
   localparam int SPARE_BIT  = 13;
   localparam int POWER_LO   = 14;
   localparam int POLICY_BIT = 16;
   localparam int WATCH_BIT  = 17;
   localparam int PUMP_BIT   = 18;
   localparam int MODULATION_SEL_BIT = 19;
   localparam int POL_BIT    = 20;
   localparam int IDLE_BIT   = 21;
   localparam int N_W        = 17;

   localparam logic [1:0]  ADDR_A       = 2'h0;
   localparam logic [11:0] A_UPPER_RST  = 12'h07C;
   localparam logic [9:0]  RR_MIN       = 10'h004;
   localparam logic [9:0]  RR_MAX       = 10'h3FF;
   localparam logic        INTERNAL_SRC = 1'b0;

   // ***********************************************************
   // power-up defaults per select pins {fs1, fs0}
   // ***********************************************************
   localparam logic [9:0]     REF_DIV_00 = 10'h010;
   localparam logic [9:0]     REF_DIV_01 = 10'h020;
   localparam logic [9:0]     REF_DIV_10 = 10'h020;
   localparam logic [9:0]     REF_DIV_11 = 10'h012;
   localparam logic [N_W-1:0] RX_N_00    = 17'h0077F;
   localparam logic [N_W-1:0] RX_N_01    = 17'h00766;
   localparam logic [N_W-1:0] RX_N_10    = 17'h00FCF;
   localparam logic [N_W-1:0] RX_N_11    = 17'h002FE;
   localparam logic [N_W-1:0] TX_N_00    = 17'h00797;
   localparam logic [N_W-1:0] TX_N_01    = 17'h00796;
   localparam logic [N_W-1:0] TX_N_10    = 17'h00FFF;
   localparam logic [N_W-1:0] TX_N_11    = 17'h00319;
   localparam logic [7:0]     VCO_TABLE  = 8'h37;
   localparam logic [3:0]     BAND_TABLE = 4'h5;

   typedef enum logic [1:0] {
      TCW_STANDBY = 2'b00,
      TCW_RECEIVE = 2'b01,
      TCW_TRANSMIT = 2'b10,
      TCW_IDLE    = 2'b11
   } tcw_mode_t;

   function automatic logic [9:0] dflt_ref(input logic [1:0] sel);
      case (sel)
         2'h0:    dflt_ref = REF_DIV_00;
         2'h1:    dflt_ref = REF_DIV_01;
         2'h2:    dflt_ref = REF_DIV_10;
         default: dflt_ref = REF_DIV_11;
      endcase
   endfunction : dflt_ref

   function automatic logic [N_W-1:0] dflt_rx_n(input logic [1:0] sel);
      case (sel)
         2'h0:    dflt_rx_n = RX_N_00;
         2'h1:    dflt_rx_n = RX_N_01;
         2'h2:    dflt_rx_n = RX_N_10;
         default: dflt_rx_n = RX_N_11;
      endcase
   endfunction : dflt_rx_n

   function automatic logic [N_W-1:0] dflt_tx_n(input logic [1:0] sel);
      case (sel)
         2'h0:    dflt_tx_n = TX_N_00;
         2'h1:    dflt_tx_n = TX_N_01;
         2'h2:    dflt_tx_n = TX_N_10;
         default: dflt_tx_n = TX_N_11;
      endcase
   endfunction : dflt_tx_n

endpackage : tcw_pkg

// File: src/tcw_shift.sv
`timescale 1ns/1ps
`default_nettype none

module tcw_shift (
   // link clock and reset
   input  wire logic                      serial_clk_i,
   input  wire logic                      reset_i,
   // serial data
   input  wire logic                      serial_data_in_i,
   output logic      [tcw_pkg::WORD_W-1:0] shift_o
);

   logic [tcw_pkg::WORD_W-1:0] shift_q;

   always_ff @(posedge serial_clk_i or posedge reset_i) begin
      if (reset_i) begin
         shift_q <= '0;
      end else begin
         shift_q <= {shift_q[tcw_pkg::WORD_W-2:0], serial_data_in_i};
      end
   end

   assign shift_o = shift_q;

   property p_shift_in;
      @(posedge serial_clk_i) disable iff (reset_i)
      1'b1 |=> shift_o == {$past(shift_o[tcw_pkg::WORD_W-2:0]), $past(serial_data_in_i)};
   endproperty
   a_shift_in: assert property (p_shift_in)
      else $error("shift register did not take serial bit");

endmodule : tcw_shift

`default_nettype wire

// File: src/tcw_sync.sv
`timescale 1ns/1ps
`default_nettype none

module tcw_sync #(
   parameter int WIDTH = 1
) (
   // clock and reset
   input  wire logic             sys_clk_i,
   input  wire logic             reset_i,
   // levels
   input  wire logic [WIDTH-1:0] async_i,
   output logic      [WIDTH-1:0] sync_o
);

   logic [WIDTH-1:0] ff1_q;
   logic [WIDTH-1:0] ff2_q;

   always_ff @(posedge sys_clk_i or posedge reset_i) begin
      if (reset_i) begin
         ff1_q <= '0;
         ff2_q <= '0;
      end else begin
         ff1_q <= async_i;
         ff2_q <= ff1_q;
      end
   end

   assign sync_o = ff2_q;

endmodule : tcw_sync

`default_nettype wire

// File: verification/tcw_control_word_a_bench.sv
`timescale 1ns/1ps
`default_nettype none

module tcw_control_word_a_bench;
   logic sys_clk_i = 1'b0;
   logic reset_i = 1'b1;
   logic serial_clk_i, serial_data_in_i, serial_enable_i;
   logic freq_select_1_i = 1'b0, pll_lock_i = 1'b0, tx_data_i = 1'b0;
   logic gain_control_source_i = 1'b0, amp_gain_ext_i = 1'b0;
   logic modulation_source_i = 1'b0, modulation_ext_i = 1'b0;
   logic programmable_mode_o, ref_osc_active_o, pll_active_o, pa_enable_o;
   logic lock_indicator_o, amp_gain_sel_o, pump_high_current_o;
   logic modulation_sel_o, tx_symbol_o, idle_scope_o, rx_div_rejected_o, band_o;
   logic [1:0] operating_mode_o, output_power_step_o, vco_current_code_o;
   logic [9:0] rx_ref_divider_o, tx_ref_divider_o, rr;
   logic [tcw_pkg::N_W-1:0] rx_feedback_divider_o, tx_feedback_divider_o;
   logic [46:0] d;
   logic [31:0] w;
   logic [23:0] a;
   logic lk;
   int n_fail = 0;
   int comparisons = 0;
   int cyc = 0;

   tcw_host host (
      .serial_clk_o     (serial_clk_i),
      .serial_data_in_o (serial_data_in_i),
      .serial_enable_o  (serial_enable_i)
   );
   tcw_control_word_a dut (.*);

   always #2 sys_clk_i = ~sys_clk_i;

   // ******************
   // helpers
   // ******************
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         n_fail++;
         $display("[ERR] %s expected %0h seen %0h", nm, exp, seen);
      end
   endtask : chk

   task automatic complete_run();
      $display("comparisons %0d mismatches %0d", comparisons, n_fail);
      if (n_fail == 0 && comparisons > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask : complete_run

   always @(posedge sys_clk_i) begin
      cyc <= cyc + 1;
      if (cyc == 40000) begin
         n_fail++;
         complete_run();
      end
   end

   // {band, vco, ref, rx n, tx n} per {fs1, fs0}
   function automatic logic [46:0] dflt(input logic [1:0] s);
      case (s)
         2'h0: dflt = {1'h1, 2'h3, 10'h010, 17'h0077F, 17'h00797};
         2'h1: dflt = {1'h0, 2'h1, 10'h020, 17'h00766, 17'h00796};
         2'h2: dflt = {1'h1, 2'h3, 10'h020, 17'h00FCF, 17'h00FFF};
         default: dflt = {1'h0, 2'h0, 10'h012, 17'h002FE, 17'h00319};
      endcase
   endfunction : dflt

   task automatic do_reset(input logic [1:0] s);
      @(negedge sys_clk_i);
      reset_i = 1'b1;
      freq_select_1_i = s[1];
      host.strap(s[0]);
      repeat (4) @(negedge sys_clk_i);
      reset_i = 1'b0;
      repeat (6) @(negedge sys_clk_i);
   endtask : do_reset

   task automatic check_word(input logic [23:0] x, input logic [9:0] r, input logic keep);
      lk = (x[11:10] != 2'h0) && (pll_lock_i || (keep && !x[17] && lk));
      chk("mode", operating_mode_o, x[11:10]);
      chk("rx ref", rx_ref_divider_o, r);
      chk("power", output_power_step_o, x[15:14]);
      chk("pump", pump_high_current_o, x[18]);
      chk("gain", amp_gain_sel_o, gain_control_source_i ? amp_gain_ext_i : x[12]);
      chk("mod", modulation_sel_o, modulation_source_i ? modulation_ext_i : x[19]);
      chk("symbol", tx_symbol_o, tx_data_i ^ x[20]);
      chk("lock", lock_indicator_o, lk);
      chk("pa", pa_enable_o, x[11:10] == 2'h2 && (x[16] || lk));
      chk("scope", idle_scope_o, x[21]);
      if (x[11:10] == 2'h3) begin
         chk("pll idle", {ref_osc_active_o, pll_active_o}, {1'b1, x[21]});
      end
   endtask : check_word

   task automatic put(input logic [31:0] v, input int n);
      @(negedge sys_clk_i);
      {pll_lock_i, tx_data_i, gain_control_source_i} = 3'($urandom);
      {amp_gain_ext_i, modulation_source_i, modulation_ext_i} = 3'($urandom);
      host.send(v, n);
      repeat (8) @(negedge sys_clk_i);
   endtask : put

   // ******************
   // main sequence
   // ******************
   initial begin
      void'($urandom(32'h07A9));
      for (int s = 0; s < 4; s++) begin
         do_reset(s[1:0]);
         d = dflt(s[1:0]);
         chk("defaults", {band_o, vco_current_code_o, tx_ref_divider_o}, d[46:34]);
         chk("rx n", rx_feedback_divider_o, d[33:17]);
         chk("tx n", tx_feedback_divider_o, d[16:0]);
         chk("rx ref dflt", rx_ref_divider_o, d[43:34]);
         chk("prog early", programmable_mode_o, 1'b0);
      end
      do_reset(2'h0);
      for (int i = 0; i < 8; i++) begin
         w = $urandom;
         rr = (i == 0) ? 10'h004 : (i == 1) ? 10'h3FF : 10'h004 + 10'($urandom_range(1019));
         w[23:0] = {2'h0, w[21:14], 1'b1, w[12], i[1:0], rr};
         put(w, i[0] ? 32 : 24); // extra leading bits on odd passes
         chk("prog", programmable_mode_o, 1'b1);
         check_word(w[23:0], rr, 1'b0);
      end
      a = w[23:0];
      put({8'h00, 2'h1, ~a[21:0]}, 24);
      check_word(a, rr, 1'b1);
      a[9:0] = 10'h003;
      put({8'h00, a}, 24);
      check_word(a, rr, 1'b0);
      chk("rejected", rx_div_rejected_o, 1'b1);
      for (int k = 0; k < 2; k++) begin
         @(negedge sys_clk_i);
         pll_lock_i = 1'b1;
         host.send({8'h00, 6'h00, k[0], 4'h1, 1'b0, 2'h1, 10'h010}, 32);
         repeat (8) @(negedge sys_clk_i);
         chk("not rejected", rx_div_rejected_o, 1'b0);
         pll_lock_i = 1'b0;
         repeat (8) @(negedge sys_clk_i);
         chk("lock hold", lock_indicator_o, !k[0]);
      end
      complete_run();
   end
endmodule : tcw_control_word_a_bench

`default_nettype wire

// File: verification/tcw_host.sv
`timescale 1ns/1ps
`default_nettype none

module tcw_host (
   // serial control port
   output logic serial_clk_o,
   output logic serial_data_in_o,
   output logic serial_enable_o
);
   initial begin
      serial_clk_o = 1'b0;
      serial_data_in_o = 1'b0;
      serial_enable_o = 1'b0;
   end

   // ******************
   // host actions
   // ******************
   task automatic strap(input logic v);
      serial_enable_o = v;
   endtask : strap

   // msb first, clock still between frames
   task automatic send(input logic [31:0] w, input int n);
      for (int i = n - 1; i >= 0; i--) begin
         serial_data_in_o = w[i];
         #32 serial_clk_o = 1'b1;
         #32 serial_clk_o = 1'b0;
      end
      serial_data_in_o = ~w[0];
      #20 serial_enable_o = 1'b1;
      #40 serial_enable_o = 1'b0;
      #40;
   endtask : send
endmodule : tcw_host

`default_nettype wire
